// ---- hw/iso_receive_descriptor_engine.v ----
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "iso_rx_map.vh"
module iso_receive_descriptor_engine #(
  parameter IW = 3
) (
  input wire core_clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  input wire pkt_valid,
  input wire [1:0] pkt_tag,
  input wire [3:0] pkt_sync,
  input wire [15:0] pkt_len,
  output wire pkt_ready,
  output reg place_valid,
  output reg [31:0] place_addr,
  output reg pkt_drop,
  output reg receive_complete_event
);
  localparam S_IDLE = 4'h0;
  localparam S_FETCH = 4'h1;
  localparam S_LOAD = 4'h2;
  localparam S_WAIT = 4'h3;
  localparam S_ACCOUNT = 4'h4;
  localparam S_WBACK = 4'h5;
  localparam S_POST = 4'h6;
  localparam S_NEXT = 4'h7;
  localparam S_STALL = 4'h8;
  localparam S_DEAD = 4'h9;

  // ==========
  // Registers
  reg run;
  reg fill_mode;
  reg [4:0] evt_code;
  reg [31:0] command_ptr;
  reg [31:0] receive_match;
  reg [3:0] state;
  reg [27:0] blk_addr;
  reg [3:0] blk_count;
  reg [IW-1:0] idx;
  reg [IW+1:0] wcnt;
  reg [1:0] sub;
  reg refetch;
  reg [3:0] cur_op;
  reg cur_report;
  reg [1:0] cur_evt;
  reg [1:0] cur_wait;
  reg [15:0] cur_req;
  reg [31:0] cur_ptr;
  reg [15:0] room;
  reg [15:0] left;
  reg wake;
  wire [31:0] rd_word;
  wire [15:0] ctrl_low;
  wire [31:0] ctrl_word;
  wire active;
  wire pass;
  wire [1:0] eff_wait;
  wire [IW-1:0] last_idx;
  wire [IW+1:0] rd_addr;
  wire [IW+1:0] burst_words;

  // Address of descriptor k of the current block, word w
  function [31:0] desc_word_addr;
    input [27:0] base;
    input [IW-1:0] k;
    input [1:0] w;
    begin
      desc_word_addr = {base + {{(28-IW){1'b0}}, k}, w, 2'b00};
    end
  endfunction

  assign active = (state != S_IDLE) && (state != S_STALL) && (state != S_DEAD);
  assign ctrl_low = {run, 2'b00, 1'b0, state == S_DEAD, active, 5'h00, evt_code};
  assign ctrl_word = {fill_mode, 15'h0000, ctrl_low};
  assign pkt_ready = (state == S_WAIT);
  assign last_idx = fill_mode ? idx : blk_count[IW-1:0] - 1'b1;
  assign burst_words = {blk_count[IW-1:0] - 1'b1, 2'b11};
  // Per-buffer hold applies to the block's first descriptor only
  assign eff_wait = (fill_mode || idx == {IW{1'b0}}) ? cur_wait : 2'b00;
  assign rd_addr = (state == S_NEXT) ? {last_idx, `W_BRANCH} : {idx, sub};

  rx_packet_filter filter (
    .pkt_tag(pkt_tag),
    .pkt_sync(pkt_sync),
    .tag_enable(receive_match[`RM_TAG_HI:`RM_TAG_LO]),
    .match_sync(receive_match[`RM_SYNC_HI:`RM_SYNC_LO]),
    .sync_hold(eff_wait),
    .pass(pass)
  );

  desc_block_mem #(
    .AW(IW + 2),
    .DW(32)
  ) block_store (
    .core_clk(core_clk),
    .wr_en(state == S_FETCH && mem_req && mem_ack),
    .wr_addr(wcnt),
    .wr_data(mem_rdata),
    .rd_addr(rd_addr),
    .rd_data(rd_word)
  );

  // ==========
  // Register port
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      run <= 1'b0;
      fill_mode <= 1'b0;
      wake <= 1'b0;
      command_ptr <= 32'h00000000;
      receive_match <= 32'h00000000;
      reg_rdata <= 32'h00000000;
    end else begin
      wake <= 1'b0;
      if (reg_write) begin
        case (reg_addr)
          `REG_CONTEXT_CONTROL: begin
            run <= reg_wdata[`CC_RUN];
            wake <= reg_wdata[`CC_WAKE];
            if (!run) begin
              fill_mode <= reg_wdata[`CC_FILL_MODE];
            end
          end
          `REG_COMMAND_PTR: command_ptr <= reg_wdata;
          `REG_RECEIVE_MATCH: receive_match <= reg_wdata;
          default: ;
        endcase
      end
      reg_rdata <= 32'h00000000;
      if (reg_read) begin
        case (reg_addr)
          `REG_CONTEXT_CONTROL: reg_rdata <= ctrl_word;
          `REG_COMMAND_PTR: reg_rdata <= command_ptr;
          `REG_RECEIVE_MATCH: reg_rdata <= receive_match;
          `REG_DESC_ADDR: reg_rdata <= desc_word_addr(blk_addr, idx, 2'b00);
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========
  // Descriptor engine
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      blk_addr <= 28'h0000000;
      blk_count <= 4'h0;
      idx <= {IW{1'b0}};
      wcnt <= {(IW+2){1'b0}};
      sub <= 2'b00;
      refetch <= 1'b0;
      cur_op <= 4'h0;
      cur_report <= 1'b0;
      cur_evt <= 2'b00;
      cur_wait <= 2'b00;
      cur_req <= 16'h0000;
      cur_ptr <= 32'h00000000;
      room <= 16'h0000;
      left <= 16'h0000;
      evt_code <= `EVT_NONE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      place_valid <= 1'b0;
      place_addr <= 32'h00000000;
      pkt_drop <= 1'b0;
      receive_complete_event <= 1'b0;
    end else begin
      place_valid <= 1'b0;
      pkt_drop <= 1'b0;
      receive_complete_event <= 1'b0;
      if (!run) begin
        state <= S_IDLE;
        mem_req <= 1'b0;
        mem_we <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            if (command_ptr[3:0] == 4'h0 || command_ptr[3:0] > `Z_MAX) begin
              state <= S_DEAD;
            end else begin
              blk_addr <= command_ptr[31:4];
              blk_count <= command_ptr[3:0];
              wcnt <= {(IW+2){1'b0}};
              left <= 16'h0000;
              refetch <= 1'b0;
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= {command_ptr[31:4], 4'h0};
              state <= S_FETCH;
            end
          end
          // Whole block read as one burst of words
          S_FETCH: begin
            if (mem_ack) begin
              wcnt <= wcnt + 1'b1;
              mem_addr <= mem_addr + 32'h00000004;
              if (wcnt == burst_words) begin
                mem_req <= 1'b0;
                idx <= {IW{1'b0}};
                sub <= 2'b00;
                state <= refetch ? S_NEXT : S_LOAD;
              end
            end
          end
          S_LOAD: begin
            sub <= sub + 1'b1;
            if (sub == 2'b01) begin
              cur_op <= rd_word[`D_OP_HI:`D_OP_LO];
              cur_report <= rd_word[`D_REPORT] | fill_mode;
              cur_evt <= rd_word[`D_EVT_HI:`D_EVT_LO];
              cur_wait <= rd_word[`D_WAIT_HI:`D_WAIT_LO];
              cur_req <= rd_word[`D_SIZE_HI:0];
              room <= rd_word[`D_SIZE_HI:0];
            end
            if (sub == 2'b10) begin
              cur_ptr <= rd_word;
              sub <= 2'b00;
              state <= (left != 16'h0000) ? S_ACCOUNT : S_WAIT;
            end
          end
          S_WAIT: begin
            if (pkt_valid) begin
              if (pass) begin
                left <= pkt_len;
                evt_code <= `EVT_DONE;
                place_valid <= 1'b1;
                place_addr <= cur_ptr + {16'h0000, cur_req - room};
                state <= S_ACCOUNT;
              end else begin
                pkt_drop <= 1'b1;
              end
            end
          end
          S_ACCOUNT: begin
            if (left <= room) begin
              room <= room - left;
              left <= 16'h0000;
              state <= cur_report ? S_WBACK : S_POST;
            end else if (!fill_mode && cur_op == `OP_CONTINUE &&
                         {1'b0, idx} + 1'b1 < blk_count) begin
              left <= left - room;
              room <= 16'h0000;
              idx <= idx + 1'b1;
              state <= S_LOAD;
            end else if (fill_mode) begin
              left <= left - room;
              room <= 16'h0000;
              state <= S_WBACK;
            end else begin
              left <= 16'h0000;
              room <= 16'h0000;
              evt_code <= `EVT_LONG;
              state <= cur_report ? S_WBACK : S_POST;
            end
            if (state == S_ACCOUNT && (left <= room || fill_mode || cur_report)) begin
              mem_addr <= desc_word_addr(blk_addr, idx, 2'b11);
              mem_wdata <= {ctrl_low[15:5], evt_code, 16'h0000};
            end
          end
          // Status and residual written as one word
          S_WBACK: begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_wdata[15:0] <= room;
            mem_wdata[4+16:16] <= evt_code;
            if (mem_req && mem_ack) begin
              mem_req <= 1'b0;
              mem_we <= 1'b0;
              state <= S_POST;
            end
          end
          S_POST: begin
            if (cur_evt == `CTL_ON && (!fill_mode || room == 16'h0000)) begin
              receive_complete_event <= 1'b1;
            end
            sub <= 2'b00;
            state <= (fill_mode && room != 16'h0000) ? S_WAIT : S_NEXT;
          end
          // Branch word of the block's last descriptor (the current one in fill mode) decides the next block
          S_NEXT: begin
            sub <= sub + 1'b1;
            if (sub == 2'b01) begin
              sub <= 2'b00;
              if (rd_word[3:0] == 4'h0) begin
                blk_addr <= blk_addr + {{(28-IW){1'b0}}, last_idx};
                idx <= {IW{1'b0}};
                blk_count <= 4'h1;
                state <= S_STALL;
              end else if (rd_word[3:0] > `Z_MAX) begin
                state <= S_DEAD;
              end else begin
                blk_addr <= rd_word[31:4];
                blk_count <= rd_word[3:0];
                wcnt <= {(IW+2){1'b0}};
                refetch <= 1'b0;
                mem_req <= 1'b1;
                mem_addr <= {rd_word[31:4], 4'h0};
                state <= S_FETCH;
              end
            end
          end
          // Terminating descriptor reread on wake to pick up appends
          S_STALL: begin
            if (wake) begin
              wcnt <= {(IW+2){1'b0}};
              refetch <= 1'b1;
              mem_req <= 1'b1;
              mem_addr <= {blk_addr, 4'h0};
              state <= S_FETCH;
            end
          end
          S_DEAD: state <= S_DEAD;
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule // iso_receive_descriptor_engine

// ---- include/iso_rx_map.vh ----
`ifndef ISO_RX_MAP_VH
`define ISO_RX_MAP_VH
// ==========
// Register offsets
`define REG_CONTEXT_CONTROL 4'h0
`define REG_COMMAND_PTR 4'h4
`define REG_RECEIVE_MATCH 4'h8
`define REG_DESC_ADDR 4'hC
// ==========
// Context control fields
`define CC_FILL_MODE 31
`define CC_RUN 15
`define CC_WAKE 12
`define CC_DEAD 11
`define CC_ACTIVE 10
`define CC_EVT_HI 4
`define EVT_NONE 5'h00
`define EVT_DONE 5'h11
`define EVT_LONG 5'h02
// ==========
// Receive match fields
`define RM_TAG_HI 31
`define RM_TAG_LO 28
`define RM_SYNC_HI 11
`define RM_SYNC_LO 8
// ==========
// Descriptor word 0 fields
`define D_OP_HI 31
`define D_OP_LO 28
`define D_REPORT 27
`define D_EVT_HI 21
`define D_EVT_LO 20
`define D_JUMP_HI 19
`define D_JUMP_LO 18
`define D_WAIT_HI 17
`define D_WAIT_LO 16
`define D_SIZE_HI 15
`define OP_CONTINUE 4'h2
`define OP_FINAL 4'h3
`define CTL_ON 2'b11
`define Z_MAX 4'h8
`define W_BRANCH 2'h2
`define W_STATUS 4'hC
`endif

// ---- hw/desc_block_mem.v ----
`timescale 1ns/10ps
// ==========
// Descriptor block store, registered read
module desc_block_mem #(
  parameter AW = 5,
  parameter DW = 32
) (
  input wire core_clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // desc_block_mem

// ---- hw/rx_packet_filter.v ----
`timescale 1ns/10ps
`include "iso_rx_map.vh"
// ==========
// Tag and sync qualification of a packet header
module rx_packet_filter (
  input wire [1:0] pkt_tag,
  input wire [3:0] pkt_sync,
  input wire [3:0] tag_enable,
  input wire [3:0] match_sync,
  input wire [1:0] sync_hold,
  output wire pass
);
  wire tag_ok;
  wire sync_ok;

  assign tag_ok = tag_enable[pkt_tag];
  // Only 2'b11 holds; other codes act as no hold
  assign sync_ok = (sync_hold != `CTL_ON) || (pkt_sync == match_sync);
  assign pass = tag_ok && sync_ok;
endmodule // rx_packet_filter

// ---- dv/iso_rx_engine_asserts.sv ----
`timescale 1ns/10ps
// ==========
// Port checks of the receive engine
module iso_rx_engine_checker (
  input wire core_clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [31:0] reg_rdata,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire mem_ack,
  input wire pkt_valid,
  input wire [1:0] pkt_tag,
  input wire pkt_ready,
  input wire place_valid,
  input wire pkt_drop,
  input wire receive_complete_event
);
  reg [31:0] match_q;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      match_q <= 32'h0;
    end else if (reg_write && reg_addr == 4'h8) begin
      match_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_take;
    pkt_valid && pkt_ready;
  endsequence
  sequence s_word;
    mem_req && mem_ack && !mem_we && !mem_addr[3];
  endsequence
  AST_ANSWER: assert property (s_take |=> place_valid ^ pkt_drop)
    else $error("taken packet got no answer");
  AST_CAUSE: assert property (place_valid || pkt_drop |-> $past(pkt_valid && pkt_ready))
    else $error("answer without taken packet");
  AST_TAG_DROP: assert property (s_take ##0 !match_q[28 + pkt_tag] |=> pkt_drop)
    else $error("disabled tag not dropped");
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  AST_BURST: assert property (s_word |=> mem_req && !mem_we
    && mem_addr == $past(mem_addr) + 32'h4)
    else $error("burst not contiguous");
  AST_WB_OFS: assert property (mem_req && mem_we |-> mem_addr[3:0] == 4'hC)
    else $error("write-back off status word");
  AST_WB_RUN: assert property (mem_req && mem_we |-> mem_wdata[31])
    else $error("status lacks run bit");
  AST_EVT: assert property (receive_complete_event |=> !receive_complete_event)
    else $error("event longer than one cycle");
  AST_MATCH_RD: assert property (reg_read && reg_addr == 4'h8
    |=> (reg_rdata & 32'hF0000F00) == (match_q & 32'hF0000F00))
    else $error("match readback wrong");
endmodule // iso_rx_engine_checker

bind iso_receive_descriptor_engine iso_rx_engine_checker chk_u (.core_clk(core_clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .pkt_valid(pkt_valid),
  .pkt_tag(pkt_tag), .pkt_ready(pkt_ready), .place_valid(place_valid), .pkt_drop(pkt_drop),
  .receive_complete_event(receive_complete_event));

// ---- dv/iso_rx_mem_model.sv ----
`timescale 1ns/10ps
// ==========
// Host memory with programmable ack latency
module iso_rx_mem_model (
  input wire core_clk,
  input wire reset,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [3:0] lat,
  output reg mem_ack,
  output reg [31:0] mem_rdata
);
  logic [31:0] mem [0:1023];
  logic [3:0] cnt;
  // Idle read bus toggles so stale words never look valid
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_ack || !mem_req || cnt < lat) begin
      mem_ack <= 1'b0;
      cnt <= (mem_ack || !mem_req) ? 4'h0 : cnt + 4'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[11:2]];
      if (mem_we) begin
        mem[mem_addr[11:2]] <= mem_wdata;
      end
    end
  end
endmodule // iso_rx_mem_model

// ---- dv/test_iso_receive_descriptor_engine.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, e, a); end end
module test_iso_receive_descriptor_engine;
  logic core_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, pkt_valid = 1'b0;
  logic mem_req, mem_we, mem_ack, pkt_ready, place_valid, pkt_drop, receive_complete_event;
  logic [3:0] reg_addr = 4'h0, pkt_sync = 4'h0, lat = 4'h0;
  logic [1:0] pkt_tag = 2'h0;
  logic [15:0] pkt_len = 16'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_wdata, mem_rdata, place_addr, d;
  int errors = 0, n_checks = 0, n_wr = 0, n_evt = 0, cyc = 0, w, e;
  iso_receive_descriptor_engine dut_u (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pkt_valid(pkt_valid), .pkt_tag(pkt_tag),
    .pkt_sync(pkt_sync), .pkt_len(pkt_len), .pkt_ready(pkt_ready), .place_valid(place_valid),
    .place_addr(place_addr), .pkt_drop(pkt_drop), .receive_complete_event(receive_complete_event));
  iso_rx_mem_model mem_u (.core_clk(core_clk), .reset(reset), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // ==========
  // Clock, counters, watchdog
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    n_wr += int'(mem_ack && mem_we);
    n_evt += int'(receive_complete_event);
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  // ==========
  // Bus and packet tasks
  task rst();
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task dsc(input logic [11:0] a, input logic [31:0] w0, p, b);
    mem_u.mem[a[11:2]] = w0;
    mem_u.mem[a[11:2] + 1] = p;
    mem_u.mem[a[11:2] + 2] = b;
    mem_u.mem[a[11:2] + 3] = 32'h0;
  endtask
  task send(input logic [1:0] t, input logic [3:0] s, input logic [15:0] n,
            input logic drop, input logic [31:0] pa);
    int i;
    @(posedge core_clk);
    pkt_valid <= 1'b1;
    pkt_tag <= t;
    pkt_sync <= s;
    pkt_len <= n;
    @(negedge core_clk);
    for (i = 0; i < 300 && pkt_ready !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    pkt_valid <= 1'b0;
    @(negedge core_clk);
    `CHK("drop", drop, pkt_drop)
    `CHK("place", !drop, place_valid)
    if (!drop) `CHK("addr", pa, place_addr)
  endtask
  task wait_wr(input int n);
    int i;
    for (i = 0; i < 300 && n_wr < n; i++) @(negedge core_clk);
    `CHK("writes", n, n_wr)
  endtask
  // ==========
  // Scenarios
  task t_regs();
    rst();
    wr(4'h8, 32'h5000_0700);
    rd(4'h8);
    `CHK("match", 32'h5000_0700, d & 32'hF000_0F00)
    rd(4'h2);
    `CHK("unmapped", 32'h0, d)
    wr(4'h4, 32'h0000_0109);
    wr(4'h0, 32'h0000_8000);
    repeat (5) @(posedge core_clk);
    rd(4'h0);
    `CHK("dead", 1'b1, d[11])
    $display("test regs done");
  endtask
  task t_ppb();
    rst();
    dsc(12'h100, 32'h2003_0008, 32'h1000, 32'h0);
    dsc(12'h110, 32'h383C_0020, 32'h2000, 32'h0);
    wr(4'h8, 32'h1000_0500);
    wr(4'h4, 32'h0000_0102);
    wr(4'h0, 32'h0000_8000);
    w = n_wr;
    e = n_evt;
    send(2'h1, 4'h5, 16'h4, 1'b1, 32'h0);
    send(2'h0, 4'h3, 16'h4, 1'b1, 32'h0);
    send(2'h0, 4'h5, 16'h10, 1'b0, 32'h1000);
    wait_wr(w + 1);
    d = mem_u.mem['h47];
    `CHK("residual", 16'h0018, d[15:0])
    `CHK("status", 6'h31, {d[31], d[20:16]})
    repeat (3) @(negedge core_clk);
    `CHK("events", e + 1, n_evt)
    `CHK("no status", 32'h0, mem_u.mem['h43])
    $display("test per_buffer done");
  endtask
  task t_append();
    lat <= 4'h2;
    dsc(12'h200, 32'h300D_0010, 32'h3000, 32'h0);
    mem_u.mem['h46] = 32'h0000_0201;
    wr(4'h0, 32'h0000_9000);
    w = n_wr;
    send(2'h0, 4'h3, 16'h4, 1'b0, 32'h3000);
    repeat (30) @(posedge core_clk);
    `CHK("no writes", w, n_wr)
    `CHK("untouched", 32'h0, mem_u.mem['h83])
    rd(4'hC);
    `CHK("desc addr", 32'h0000_0200, d)
    $display("test append done");
  endtask
  task t_fill();
    rst();
    lat <= 4'h3;
    dsc(12'h300, 32'h203F_0010, 32'h4000, 32'h311);
    dsc(12'h310, 32'h200C_0010, 32'h5000, 32'h0);
    wr(4'h8, 32'hF000_0500);
    wr(4'h0, 32'h8000_0000);
    wr(4'h4, 32'h0000_0301);
    wr(4'h0, 32'h8000_8000);
    w = n_wr;
    e = n_evt;
    send(2'h2, 4'h5, 16'h4, 1'b0, 32'h4000);
    wait_wr(w + 1);
    d = mem_u.mem['hC3];
    `CHK("fill residual", 17'h1000C, {d[31], d[15:0]})
    send(2'h2, 4'h3, 16'h4, 1'b1, 32'h0);
    send(2'h2, 4'h5, 16'h4, 1'b0, 32'h4004);
    wait_wr(w + 2);
    d = mem_u.mem['hC3];
    `CHK("fill residual", 16'h0008, d[15:0])
    repeat (3) @(negedge core_clk);
    `CHK("fill events", e, n_evt)
    $display("test buffer_fill done");
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    t_regs();
    t_ppb();
    t_append();
    t_fill();
    stop_test();
  end
endmodule // test_iso_receive_descriptor_engine
